// *** hdl/fpt_params.svh ***
// Offsets, field positions, reset values and timing counts of the fan block.
// What this block does
// RULE1: Alias address reaches the same configuration storage.
// RULE2: Configuration bits 7 and 6 read zero.
// RULE3: Program disabled: duty computed, duty/table read-only.
// RULE4: Program enabled: host writes duty and table.
// RULE5: Polarity bit selects open-drain fan on/off sense.
// RULE6: Clock select: 0 is 360 kHz, 1 is 1.4 kHz.
// RULE7: Host writes zero into reserved bit 2.
// RULE8: Modes 00/01 plain; 01 saturates all ones.
// RULE9: Modes 10/11 smart-tach, all ones when slow.
// RULE10: Fast master clock forces tachometer mode 00.
// RULE11: Output frequency is master clock over 2n.
// RULE12: Configuration resets to 0x20, program enabled.
`ifndef FPT_PARAMS_SVH
`define FPT_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FPT_CFG_OFS 8'h4A
`define FPT_CFG_ALIAS_OFS 8'h4E
`define FPT_TCNT_LO_OFS 8'h46
`define FPT_TCNT_HI_OFS 8'h47
`define FPT_DUTY_OFS 8'h4C
`define FPT_FREQ_OFS 8'h4D
`define FPT_LUT_BASE 8'h50
`define FPT_LUT_LAST 8'h5F

// ****************************************************************
// Configuration fields and reset values
// ****************************************************************
`define FPT_PE_BIT 5
`define FPT_POL_BIT 4
`define FPT_CSEL_BIT 3
`define FPT_CFG_KEEP 8'h3B
`define FPT_CFG_RST 8'h20
`define FPT_FREQ_RST 5'h17
`define FPT_TACH_SAT 16'hFFFF

// ****************************************************************
// Timing
// ****************************************************************
`define FPT_CLK_HZ 100_000_000
`define FPT_MCLK_HI_HZ 360_000
`define FPT_MCLK_LO_HZ 1_400
`define FPT_TACH_TB_HZ 100_000
`define FPT_HI_DIV (`FPT_CLK_HZ / `FPT_MCLK_HI_HZ)
`define FPT_LO_DIV (`FPT_CLK_HZ / `FPT_MCLK_LO_HZ)
`define FPT_TACH_DIV (`FPT_CLK_HZ / `FPT_TACH_TB_HZ)

`endif

// *** hdl/fpt_pkg.sv ***
// Types shared by the fan drive and speed sense logic.
package fpt_pkg;
  // Effective speed sense mode, in the order of the two mode bits.
  typedef enum logic [1:0] {
    FPT_TACH_PLAIN,
    FPT_TACH_PLAIN_SAT,
    FPT_TACH_SMART_ACC,
    FPT_TACH_SMART_LIGHT
  } fpt_tach_mode_t;

  // Speed sense measurement state.
  typedef enum logic {
    FPT_TS_IDLE,
    FPT_TS_RUN
  } fpt_tach_state_t;
endpackage : fpt_pkg

// *** hdl/fpt_pwm_gen.sv ***
// Master clock prescaler and PWM period counter.
`timescale 1ns/100ps
`include "fpt_params.svh"
module fpt_pwm_gen import fpt_pkg::*; #(
  parameter int LO_DIV = `FPT_LO_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_sel,
  input wire logic [4:0] freq_n,
  input wire logic [5:0] duty,
  output logic fan_on
);
  localparam int HI_DIV = `FPT_HI_DIV;

  logic [16:0] pre_reg;
  logic [16:0] pre_next;
  logic [5:0] pos_reg;
  logic [5:0] pos_next;
  logic on_reg;
  logic on_next;
  logic [16:0] limit;
  logic tick;
  logic [4:0] n_eff;
  logic [5:0] period;

  // The prescaler turns the core clock into master PWM ticks.
  always_comb begin
    limit = clk_sel ? 17'(LO_DIV - 1) : 17'(HI_DIV - 1); // RULE6
    tick = (pre_reg >= limit);
    pre_next = tick ? 17'h0 : pre_reg + 17'h1;
    // A zero field would stall the output, so it counts as one.
    n_eff = (freq_n == 5'h0) ? 5'h1 : freq_n; // RULE11
    period = {n_eff, 1'b0}; // RULE11
    pos_next = pos_reg;
    if (tick) begin
      pos_next = (pos_reg >= period - 6'h1) ? 6'h0 : pos_reg + 6'h1;
    end
    // A duty at or above the period keeps the fan on for good.
    on_next = (pos_reg < duty);
  end

  // Registers of the prescaler and period counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_reg <= 17'h0;
      pos_reg <= 6'h0;
      on_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      pos_reg <= pos_next;
      on_reg <= on_next;
    end
  end

  assign fan_on = on_reg;

  // The prescaler never runs past the limit of the selected clock; a
  // clock change may leave it above the new limit for one cycle only.
  property p_pre_bound;
    @(posedge clk) disable iff (!rst_n)
      $stable(clk_sel) |-> pre_reg <= limit;
  endproperty
  a_pre_bound: assert property (p_pre_bound) // RULE6
    else $error("Prescaler ran past its limit.");

  // The period counter stays below two times the frequency field, a zero field counting as one.
  property p_pos_bound;
    @(posedge clk) disable iff (!rst_n)
      $stable(freq_n) && $past(tick) && $past(rst_n)
        |-> pos_reg < period;
  endproperty
  a_pos_bound: assert property (p_pos_bound) // RULE11
    else $error("PWM position left its period.");
endmodule : fpt_pwm_gen

// *** hdl/fpt_tach.sv ***
// Tachometer input synchroniser and period counter.
`timescale 1ns/100ps
`include "fpt_params.svh"
module fpt_tach import fpt_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tach_pin,
  input fpt_tach_mode_t mode,
  input wire logic fan_on,
  output logic [15:0] count
);
  localparam int TB_DIV = `FPT_TACH_DIV;

  logic s1_reg, s2_reg, s3_reg;
  logic lvl_reg, lvl_next;
  logic skip_reg, skip_next;
  logic on_d_reg;
  logic [10:0] tb_reg, tb_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] out_reg, out_next;
  fpt_tach_state_t st_reg, st_next;
  logic smart, open_win, rise, tb_tick, sat;

  // Three stages; the level moves only when stages two and three agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= tach_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Smart modes only trust pulses while the fan is powered.
  always_comb begin
    smart = (mode == FPT_TACH_SMART_ACC) || (mode == FPT_TACH_SMART_LIGHT);
    open_win = !smart || fan_on; // RULE9
    lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    rise = lvl_next && !lvl_reg && open_win;
    tb_tick = (tb_reg == 11'(TB_DIV - 1));
    tb_next = tb_tick ? 11'h0 : tb_reg + 11'h1;
    sat = (cnt_reg == `FPT_TACH_SAT);
    skip_next = skip_reg;
    st_next = st_reg;
    cnt_next = cnt_reg;
    out_next = out_reg;
    case (st_reg)
      FPT_TS_IDLE: begin
        if (rise) begin
          st_next = FPT_TS_RUN;
          cnt_next = 16'h0;
        end
      end
      FPT_TS_RUN: begin
        if (rise && skip_reg) begin
          skip_next = 1'b0;
          cnt_next = 16'h0;
        end else if (rise) begin
          out_next = cnt_reg;
          cnt_next = 16'h0;
        end else if (tb_tick && open_win) begin
          // Only the plain mode lets the count wrap to a false value.
          if (!sat || mode == FPT_TACH_PLAIN) begin // RULE8
            cnt_next = cnt_reg + 16'h1;
          end else begin
            out_next = `FPT_TACH_SAT; // RULE8 RULE9
          end
        end
      end
      default: st_next = FPT_TS_IDLE;
    endcase
    // The light mode drops the first pulse after power returns; a new
    // turn-on wins over the clear of an older pending drop.
    if (mode == FPT_TACH_SMART_LIGHT && fan_on && !on_d_reg) begin
      skip_next = 1'b1;
    end
  end

  // Registers of the measurement.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_reg <= 1'b0;
      skip_reg <= 1'b0;
      on_d_reg <= 1'b0;
      tb_reg <= 11'h0;
      cnt_reg <= 16'h0;
      out_reg <= 16'h0;
      st_reg <= FPT_TS_IDLE;
    end else begin
      lvl_reg <= lvl_next;
      skip_reg <= skip_next;
      on_d_reg <= fan_on;
      tb_reg <= tb_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      st_reg <= st_next;
    end
  end

  assign count = out_reg;

  // A saturated count in a reporting mode reads as all ones.
  property p_sat;
    @(posedge clk) disable iff (!rst_n)
      st_reg == FPT_TS_RUN && sat && tb_tick && open_win && !rise
        && mode != FPT_TACH_PLAIN |=> out_reg == `FPT_TACH_SAT;
  endproperty
  a_sat: assert property (p_sat) // RULE8
    else $error("Slow fan did not report all ones.");
endmodule : fpt_tach

// *** hdl/fpt_top.sv ***
// Fan drive configuration register file, PWM output and speed sense.
`timescale 1ns/100ps
`include "fpt_params.svh"
module fpt_top import fpt_pkg::*; #(
  parameter int LO_DIV = `FPT_LO_DIV
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] REMOTE_TEMP,
  input wire logic TACH_I,
  output logic PWM_O,
  output logic PWM_OE
);
  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] cfg_reg, cfg_next;
  logic [5:0] duty_reg, duty_next;
  logic [4:0] freq_reg, freq_next;
  logic [7:0] lut_reg [16];
  logic [7:0] lut_next [16];
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] hit;
  logic [5:0] auto_duty;
  logic [7:0] rmux;
  logic [15:0] tcount;
  logic fan_on;
  logic sel_cfg, sel_lut, prog_en;
  fpt_tach_mode_t eff_mode;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Both addresses select one storage; nothing is duplicated.
  assign sel_cfg = (ADDR == `FPT_CFG_OFS) || (ADDR == `FPT_CFG_ALIAS_OFS); // RULE1
  assign sel_lut = (ADDR >= `FPT_LUT_BASE) && (ADDR <= `FPT_LUT_LAST);
  assign prog_en = cfg_reg[`FPT_PE_BIT];

  // ****************************************************************
  // Temperature lookup
  // ****************************************************************

  // Each pair holds a temperature threshold and the duty used above it.
  generate
    for (genvar i = 0; i < 8; i++) begin : g_hit
      assign hit[i] = (REMOTE_TEMP >= lut_reg[2 * i]);
    end
  endgenerate

  // The highest pair that the temperature reaches wins, so the table
  // is expected in rising temperature order.
  always_comb begin
    auto_duty = 6'h0;
    for (int i = 0; i < 8; i++) begin
      if (hit[i]) begin
        auto_duty = lut_reg[2 * i + 1][5:0]; // RULE3
      end
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************

  // Writes and the automatic duty update.
  always_comb begin
    cfg_next = cfg_reg;
    freq_next = freq_reg;
    duty_next = duty_reg;
    for (int i = 0; i < 16; i++) begin
      lut_next[i] = lut_reg[i];
    end
    if (WR && sel_cfg) begin
      // Bits 7, 6 and the reserved bit 2 are never stored.
      cfg_next = WDATA & `FPT_CFG_KEEP; // RULE1 RULE2 RULE7
    end
    if (WR && ADDR == `FPT_FREQ_OFS) begin
      freq_next = WDATA[4:0];
    end
    if (!prog_en) begin
      // The table and the duty register ignore writes here.
      duty_next = auto_duty; // RULE3
    end else begin
      if (WR && ADDR == `FPT_DUTY_OFS) begin
        duty_next = WDATA[5:0]; // RULE4
      end
      if (WR && sel_lut) begin
        lut_next[ADDR[3:0]] = WDATA; // RULE4
      end
    end
  end

  // Registers of the register file.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cfg_reg <= `FPT_CFG_RST; // RULE12
      freq_reg <= `FPT_FREQ_RST;
      duty_reg <= 6'h0;
      for (int i = 0; i < 16; i++) begin
        lut_reg[i] <= 8'h0;
      end
    end else begin
      cfg_reg <= cfg_next;
      freq_reg <= freq_next;
      duty_reg <= duty_next;
      for (int i = 0; i < 16; i++) begin
        lut_reg[i] <= lut_next[i];
      end
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************

  // Unmapped addresses read zero; data stand for one cycle only.
  always_comb begin
    rmux = 8'h0;
    if (sel_cfg) begin
      rmux = cfg_reg & `FPT_CFG_KEEP; // RULE1 RULE2
    end else if (sel_lut) begin
      rmux = lut_reg[ADDR[3:0]];
    end else begin
      case (ADDR)
        `FPT_DUTY_OFS: rmux = {2'b00, duty_reg}; // RULE3
        `FPT_FREQ_OFS: rmux = {3'b000, freq_reg};
        `FPT_TCNT_LO_OFS: rmux = tcount[7:0];
        `FPT_TCNT_HI_OFS: rmux = tcount[15:8];
        default: rmux = 8'h0;
      endcase
    end
    rdata_next = RD ? rmux : 8'h0;
  end

  // Read data register.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdata_reg <= 8'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;

  // ****************************************************************
  // PWM output and speed sense
  // ****************************************************************

  // PWM timing from the selected master clock and frequency field.
  fpt_pwm_gen #(
    .LO_DIV(LO_DIV)
  ) u_pwm (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .clk_sel(cfg_reg[`FPT_CSEL_BIT]),
    .freq_n(freq_reg),
    .duty(duty_reg),
    .fan_on(fan_on)
  );

  // The pin only ever pulls low; releasing it lets it float high.
  assign PWM_O = 1'b0;
  assign PWM_OE = cfg_reg[`FPT_POL_BIT] ? fan_on : !fan_on; // RULE5

  // Smart modes need the slow clock; the fast one forces plain mode.
  assign eff_mode = cfg_reg[`FPT_CSEL_BIT] ?
    fpt_tach_mode_t'(cfg_reg[1:0]) : FPT_TACH_PLAIN; // RULE10

  // Speed measurement.
  fpt_tach u_tach (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .tach_pin(TACH_I),
    .mode(eff_mode),
    .fan_on(fan_on),
    .count(tcount)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************

  // A write at the alias is visible at the primary address.
  property p_alias;
    @(posedge CORE_CLK) disable iff (!RST_N)
      WR && ADDR == `FPT_CFG_ALIAS_OFS ##1 RD && ADDR == `FPT_CFG_OFS
        |=> RDATA == ($past(WDATA, 2) & `FPT_CFG_KEEP);
  endproperty
  a_alias: assert property (p_alias) // RULE1
    else $error("Alias write not seen at primary address.");

  // Unimplemented and reserved bits read zero.
  property p_zero_bits;
    @(posedge CORE_CLK) disable iff (!RST_N)
      RD && sel_cfg |=> RDATA[7:6] == 2'b00 && RDATA[2] == 1'b0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) // RULE2
    else $error("Unused configuration bits read nonzero.");

  // The table is frozen while program mode is off.
  property p_lut_lock;
    @(posedge CORE_CLK) disable iff (!RST_N)
      WR && sel_lut && !prog_en |=> lut_reg[$past(ADDR[3:0])] ==
        $past(lut_reg[ADDR[3:0]]);
  endproperty
  a_lut_lock: assert property (p_lut_lock) // RULE3
    else $error("Table changed while program mode was off.");

  // Automatic duty follows the table one cycle later.
  property p_auto;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !prog_en && !(WR && sel_cfg) |=> duty_reg == $past(auto_duty);
  endproperty
  a_auto: assert property (p_auto) // RULE3
    else $error("Automatic duty did not follow the table.");

  // A host duty write in program mode lands as written.
  property p_duty_wr;
    @(posedge CORE_CLK) disable iff (!RST_N)
      WR && ADDR == `FPT_DUTY_OFS && prog_en |=> duty_reg == $past(WDATA[5:0]);
  endproperty
  a_duty_wr: assert property (p_duty_wr) // RULE4
    else $error("Duty write was lost.");

  // The pin drive follows the fan state and the polarity.
  property p_pol;
    @(posedge CORE_CLK) disable iff (!RST_N)
      PWM_O == 1'b0 && (PWM_OE == (fan_on == cfg_reg[`FPT_POL_BIT]));
  endproperty
  a_pol: assert property (p_pol) // RULE5
    else $error("Output sense disagrees with polarity.");

  // The fast master clock always gives plain speed sensing.
  property p_fast_plain;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !cfg_reg[`FPT_CSEL_BIT] |-> eff_mode == FPT_TACH_PLAIN;
  endproperty
  a_fast_plain: assert property (p_fast_plain) // RULE10
    else $error("Smart mode active on the fast clock.");

  // Configuration comes out of reset with only program mode set.
  property p_reset;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $past(!RST_N) |-> cfg_reg == `FPT_CFG_RST;
  endproperty
  a_reset: assert property (p_reset) // RULE12
    else $error("Configuration reset value wrong.");

  // A table write in program mode lands as written.
  property p_lut_wr;
    @(posedge CORE_CLK) disable iff (!RST_N)
      WR && sel_lut && prog_en |=> lut_reg[$past(ADDR[3:0])] ==
        $past(WDATA);
  endproperty
  a_lut_wr: assert property (p_lut_wr) // RULE4
    else $error("Table write was lost in program mode.");

  // A refused duty write leaves the table in charge of the duty.
  property p_duty_refuse;
    @(posedge CORE_CLK) disable iff (!RST_N)
      WR && ADDR == `FPT_DUTY_OFS && !prog_en |=>
        duty_reg == $past(auto_duty);
  endproperty
  a_duty_refuse: assert property (p_duty_refuse) // RULE3
    else $error("Duty write was taken while program mode was off.");

  // Configuration only changes on a write to one of its two addresses.
  property p_cfg_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !(WR && sel_cfg) |=> $stable(cfg_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) // RULE1
    else $error("Configuration changed without a write.");

  // A configuration read returns every stored field unchanged.
  property p_rd_cfg;
    @(posedge CORE_CLK) disable iff (!RST_N)
      RD && sel_cfg |=> RDATA[5:3] == $past(cfg_reg[5:3]) &&
        RDATA[1:0] == $past(cfg_reg[1:0]);
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) // RULE1
    else $error("Configuration read lost a stored field.");

  // The frequency field takes the low five bits of a write.
  property p_freq_wr;
    @(posedge CORE_CLK) disable iff (!RST_N)
      WR && ADDR == `FPT_FREQ_OFS |=> freq_reg == $past(WDATA[4:0]);
  endproperty
  a_freq_wr: assert property (p_freq_wr) // RULE11
    else $error("Frequency field write was lost.");

  // With no duty the fan stays off in either output sense.
  property p_off_sense;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $past(duty_reg) == 6'h0 |-> PWM_OE != cfg_reg[`FPT_POL_BIT];
  endproperty
  a_off_sense: assert property (p_off_sense) // RULE5
    else $error("Fan driven on with zero duty.");

  // Both upper modes on the slow clock enable smart sensing.
  property p_smart_on;
    @(posedge CORE_CLK) disable iff (!RST_N)
      cfg_reg[`FPT_CSEL_BIT] && cfg_reg[1] |->
        (eff_mode == FPT_TACH_SMART_ACC || eff_mode == FPT_TACH_SMART_LIGHT);
  endproperty
  a_smart_on: assert property (p_smart_on) // RULE9
    else $error("Smart speed sensing not enabled.");
endmodule : fpt_top

// *** dv/fpt_fan_model.sv ***
// Behavioural fan: open-drain power switch load and tachometer source.
`timescale 1ns/100ps
module fpt_fan_model (
  input wire logic clk,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic pol,
  input wire logic [15:0] half,
  output logic tach
);
  // ****************************************************************
  // Power decode, inertia and tach pulses
  // ****************************************************************
  logic level;
  logic powered;
  int coast;
  int ph;
  // The pin has a pull-up, so a released pin reads high.
  assign level = pin_oe ? pin_o : 1'b1;
  // Fan power follows the pin in the sense the polarity bit selects.
  assign powered = pol ? ~level : level;
  initial begin
    tach = 1'b0;
    coast = 0;
    ph = 0;
  end
  // Rotor inertia keeps the tach running through short off phases.
  always @(posedge clk) begin
    if (powered) begin
      coast <= 3000;
    end else if (coast > 0) begin
      coast <= coast - 1;
    end
    if (coast > 0) begin
      ph <= (ph + 1 >= half) ? 0 : ph + 1;
      if (ph + 1 >= half) begin
        tach <= ~tach;
      end
    end
  end
endmodule : fpt_fan_model

// *** dv/testbench.sv ***
// Self-checking bench for the fan drive configuration block.
`timescale 1ns/100ps
`include "fpt_params.svh"
module testbench;
  import fpt_pkg::*;
  typedef struct {logic [15:0] val; int tol;} fpt_exp_t;
  localparam int LO = 20;
  localparam int TP = 4000;
  localparam int LIMIT = 70000;
  logic clk, rst_n, wr, rd, rd_d, tach, pwm_o, pwm_oe, cur_pol, on_w;
  logic [7:0] addr, wdata, rdata, temp;
  logic [31:0] seed;
  int n_mismatch, total_checks, cyc;
  fpt_exp_t exp_q[$];
  assign on_w = (pwm_oe === cur_pol);
  fpt_top #(.LO_DIV(LO)) i_fpt_top (.CORE_CLK(clk), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .REMOTE_TEMP(temp), .TACH_I(tach), .PWM_O(pwm_o), .PWM_OE(pwm_oe));
  fpt_fan_model i_fpt_fan_model (.clk(clk), .pin_o(pwm_o), .pin_oe(pwm_oe),
    .pol(cur_pol), .half(16'(TP / 2)), .tach(tach));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction : lfsr
  task automatic check(input logic [15:0] got, input logic [15:0] ex,
      input int tol);
    logic ok;
    ok = (got === ex) || (tol != 0 && (got === ex + 1 || got === ex - 1));
    total_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, ex);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // A read notes its expectation before the strobe goes out.
  task automatic rreg(input logic [7:0] a, input logic [15:0] e, int tol);
    exp_q.push_back('{e, tol});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  // A write and a read in consecutive cycles, with no idle cycle between.
  task automatic wr_rd(input logic [7:0] wa, input logic [7:0] d,
      input logic [7:0] ra, input logic [15:0] e);
    exp_q.push_back('{e, 0});
    @(posedge clk);
    addr <= wa;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ra;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : wr_rd
  // Measure one fan-on time and one full period, bounded by 6 periods.
  task automatic meas(input logic [7:0] c, input logic [4:0] n, int per,
      int hi);
    int t;
    int k;
    cur_pol = c[4];
    wreg(8'h4A, c);
    wreg(8'h4D, {3'b000, n});
    wreg(8'h4C, 8'h01);
    repeat (2 * per) @(posedge clk);
    t = 0;
    while (on_w && t < 3 * per) begin @(posedge clk); t++; end
    while (!on_w && t < 6 * per) begin @(posedge clk); t++; end
    k = 0;
    while (on_w && k < 3 * per) begin @(posedge clk); k++; end
    check(16'(k), 16'(hi), 0);
    while (!on_w && k < 6 * per) begin @(posedge clk); k++; end
    check(16'(k), 16'(per), 0);
  endtask : meas
  // Program a drive setting, let a few fan revolutions pass, read count.
  task automatic tmeas(input logic [7:0] c, input logic [5:0] d);
    cur_pol = c[4];
    wreg(8'h4A, c);
    wreg(8'h4D, 8'h01);
    wreg(8'h4C, {2'b00, d});
    repeat (3 * TP) @(posedge clk);
    rreg(8'h46, 16'(TP / 1000), 1);
    rreg(8'h47, 16'h0000, 0);
  endtask : tmeas
  // ****************************************************************
  // Clock, monitor and timeout
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Each read result is compared with the oldest note on the queue.
  always @(posedge clk) begin : mon
    fpt_exp_t e;
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d === 1'b1) begin
      e = exp_q.pop_front();
      check({8'h00, rdata}, e.val, e.tol);
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int i;
    logic [7:0] v;
    logic [7:0] ra;
    {rst_n, wr, rd, rd_d, addr, wdata, cur_pol} = '0;
    temp = 8'h35;
    seed = 32'h18f4_9703;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rreg(8'h4A, 16'h0020, 0);
    rreg(8'h4E, 16'h0020, 0);
    rreg(8'h40, 16'h0000, 0);
    // Random settings through one address, read through the other.
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = seed[7:0] & 8'hFB;
      ra = i[0] ? 8'h4A : 8'h4E;
      wr_rd(ra ^ 8'h04, v, ra, {8'h00, v & 8'h3B});
    end
    wreg(8'h4A, 8'h20);
    for (i = 0; i < 8; i++) begin
      wreg(8'(8'h50 + 2 * i), 8'(16 * i));
      wreg(8'(8'h51 + 2 * i), 8'(4 * i + 1));
    end
    rreg(8'h53, 16'h0005, 0);
    wreg(8'h4C, 8'h2A);
    rreg(8'h4C, 16'h002A, 0);
    // Program disabled: the table decides duty and rejects writes.
    wreg(8'h4A, 8'h00);
    repeat (3) @(posedge clk);
    rreg(8'h4C, 16'h000D, 0);
    wreg(8'h4C, 8'h01);
    wreg(8'h52, 8'hFF);
    rreg(8'h4C, 16'h000D, 0);
    rreg(8'h52, 16'h0010, 0);
    wreg(8'h4A, 8'h20);
    // Zero duty keeps the fan off in both output senses.
    for (i = 0; i < 2; i++) begin
      wreg(8'h4A, 8'(8'h20 | (i << 4)));
      wreg(8'h4C, 8'h00);
      repeat (600) @(posedge clk);
      check({15'd0, pwm_oe}, 16'(1 - i), 0);
      check({15'd0, pwm_o}, 16'h0000, 0);
    end
    meas(8'h28, 5'd3, 6 * LO, LO);
    meas(8'h30, 5'd0, 2 * `FPT_HI_DIV, `FPT_HI_DIV);
    tmeas(8'h23, 6'h01);
    tmeas(8'h2A, 6'h3F);
    tmeas(8'h29, 6'h01);
    tmeas(8'h2B, 6'h3F);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : testbench
